/* File: host_pio_fifo_direct_port_tb.sv */
// Self-checking bench joining host and device ends over the link interface.
// Assumes a 50 ns clock and the request pacing described for the host end.
`timescale 1ns/1ps
module host_pio_fifo_direct_port_tb;
   import hpf_pkg::*;
   `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
      $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
   // -------------------------------------------------------------------
   // Stimulus and observation signals
   // -------------------------------------------------------------------
   logic              sys_clk = 1'b0, sys_rst = 1'b1;          // Clock and reset.
   logic              req_valid = 1'b0, req_write = 1'b0;     // Host request.
   logic              req_fifo = 1'b0, req_ready, rsp_valid;  // Host handshake.
   logic [ADDR_W-1:0] req_addr = '0;                          // Request address.
   logic [DATA_W-1:0] req_wdata = '0, rsp_data, q;            // Data words.
   logic [DATA_W-1:0] rx_word = '0, tx_word, reg_wdata;       // Device user side.
   logic [DATA_W-1:0] event_count = 16'h1234;                 // Counter value, moved once in t_addr.
   logic              rx_word_valid = 1'b0, rx_word_ready;    // Receive fill side.
   logic              tx_word_valid, tx_word_ready = 1'b0;    // Transmit drain side.
   logic [1:0]        reg_windex;                             // Register write index.
   logic              reg_wstrobe, burst_overrun;             // Device flags.
   int                err_count = 0, comparisons = 0, cyc = 0; // Tallies.

   hpf_link_if link ();
   hpf_host u_hpf_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_fifo(req_fifo), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid));
   hpf_device u_hpf_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
      .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
      .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
      .event_count(event_count), .reg_wdata(reg_wdata), .reg_windex(reg_windex),
      .reg_wstrobe(reg_wstrobe), .burst_overrun(burst_overrun));
   hpf_link_asserts u_hpf_link_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .chip_select_low(link.chip_select_low), .read_strobe_low(link.read_strobe_low),
      .write_strobe_low(link.write_strobe_low), .fifo_sel(link.fifo_sel), .addr(link.addr),
      .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
      .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe));

   // Clock toggles every half period of 25 ns.
   always #25 sys_clk = ~sys_clk;

   // Prints the tallies and the verdict, then stops the run.
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // A hang is cut short well past the 23 requests expected.
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         final_report();
      end
   end

   // One host request; a read leaves its answer in q.
   task automatic req(input logic w, f, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge sys_clk); #1;
      req_valid = 1'b1; req_write = w; req_fifo = f; req_addr = a; req_wdata = d;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk); #1; n++;
      end
      @(posedge sys_clk); #1;
      req_valid = 1'b0;
      n = 0;
      // Writes give no answer, so only reads wait for the pulse.
      if (!w)
         do begin @(posedge sys_clk); #1; n++; end while (rsp_valid !== 1'b1 && n < 20);
      q = rsp_data;
   endtask

   // Receive FIFO: empty read, fill until refused, then drain by FIFO-direct reads.
   task automatic t_rx;
      req(1'b0, 1'b1, 7'h7C, '0);
      `CHK(q, RST_DATA)
      for (int i = 0; i < 9; i++)
      begin
         @(posedge sys_clk); #1;
         rx_word = 16'hA000 + 16'(i); rx_word_valid = 1'b1;
         `CHK(rx_word_ready, logic'(i < 8))
      end
      @(posedge sys_clk); #1 rx_word_valid = 1'b0;
      req(1'b0, 1'b0, {5'h00, STATUS_IDX}, '0);
      `CHK(q, 16'h0001)
      // Upper address bits wander as an incrementing host would drive them.
      for (int i = 0; i < 8; i++)
      begin
         req(1'b0, 1'b1, {5'(i * 3 + 1), RX_DATA_IDX}, '0);
         `CHK(q, 16'hA000 + 16'(i))
      end
      $display("Test rx direct done");
   endtask

   // Transmit FIFO: nine direct writes while drain stalls, the ninth is dropped.
   task automatic t_tx;
      for (int i = 0; i < 9; i++)
         req(1'b1, 1'b1, {5'(i * 7 + 2), 2'h0}, 16'hB000 + 16'(i));
      req(1'b0, 1'b0, {5'h00, STATUS_IDX}, '0);
      `CHK(q, 16'h0002)
      tx_word_ready = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         `CHK(tx_word_valid, 1'b1)
         `CHK(tx_word, 16'hB000 + 16'(i))
         @(posedge sys_clk); #1;
      end
      tx_word_ready = 1'b0;
      `CHK(tx_word_valid, 1'b0)
      $display("Test tx direct done");
   endtask

   // Addressed reads of the test word and the counter, and an addressed write to a register index.
   task automatic t_addr;
      int n;
      n = 0;
      req(1'b0, 1'b0, {5'h00, TEST_IDX}, '0);
      `CHK(q, TEST_WORD)
      // The counter moves after the read has started; the answer keeps the old value.
      fork
         req(1'b0, 1'b0, {5'h00, COUNT_IDX}, '0);
         begin
            wait (link.read_strobe_low === 1'b0);
            repeat (3) @(posedge sys_clk);
            #1 event_count = 16'h5678;
         end
      join
      `CHK(q, 16'h1234)
      req(1'b1, 1'b0, {5'h00, STATUS_IDX}, 16'hC0DE);
      while (reg_wstrobe !== 1'b1 && n < 20)
      begin
         @(posedge sys_clk); #1; n++;
      end
      `CHK(reg_wdata, 16'hC0DE)
      `CHK(reg_windex, STATUS_IDX)
      @(posedge sys_clk); #1;
      `CHK(reg_wstrobe, 1'b0)
      `CHK(tx_word_valid, 1'b0)
      `CHK(burst_overrun, 1'b0)
      $display("Test addressed done");
   endtask

   // Main sequence: reset for 16 cycles, then each scenario in turn.
   initial
   begin
      repeat (16) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      t_rx();
      t_tx();
      t_addr();
      final_report();
   end
endmodule // host_pio_fifo_direct_port_tb

/* File: hpf_device.sv */
// Device end of the host parallel port: strobe sampling, decode, data FIFOs.
// Assumes host pins arrive asynchronously and the link interface joins the host.
//
// What this block does
// - FIFO select read returns receive FIFO data.
// - FIFO select write pushes transmit FIFO.
// - Decode A[2:1]; ignore A[7:3] in FIFO mode.
// - FIFO select sampled together with address.
// - FIFO-direct burst reads have no length limit.
// - Read spans both strobes low; ends either high.
// - Write spans both strobes low; ends either high.
// - All writes are single cycles, no burst.
// - Write data captured at cycle end.
// - Host keeps each cycle at least 165 ns.
// - Host keeps strobes high 13 ns between cycles.
// - Host keeps strobes low at least 32 ns.
// - Addressed burst reads at most 16 words.
// - Counter value latched at read start.
`timescale 1ns/1ps
module hpf_device
   import hpf_pkg::*;
(
   input  wire logic              sys_clk,        // System clock.
   input  wire logic              sys_rst,        // Synchronous reset.
   hpf_link_if.device             link,           // Pins towards the host.
   input  wire logic [DATA_W-1:0] rx_word,        // Received word to queue.
   input  wire logic              rx_word_valid,  // Received word offered.
   output logic                   rx_word_ready,  // Receive FIFO has room.
   output logic      [DATA_W-1:0] tx_word,        // Oldest transmit word.
   output logic                   tx_word_valid,  // Transmit word available.
   input  wire logic              tx_word_ready,  // Transmit word taken.
   input  wire logic [DATA_W-1:0] event_count,    // Live counter to expose.
   output logic      [DATA_W-1:0] reg_wdata,      // Last register write data.
   output logic      [1:0]        reg_windex,     // Last register write index.
   output logic                   reg_wstrobe,    // Register write pulse.
   output logic                   burst_overrun   // Addressed burst passed limit.
);
   // -------------------------------------------------------------------
   // Synchronisers
   // -------------------------------------------------------------------
   logic [2:0] ctl_meta;                 // First stage: cs, rd, wr.
   logic [2:0] ctl_sync;                 // Second stage, safe to read.
   logic [2:0] ctl_prev;                 // Declared but never assigned or read.
   logic       rd_active;                // Read cycle under way.
   logic       wr_active;                // Write cycle under way.
   logic       rd_was;                   // Read active last cycle.
   logic       wr_was;                   // Write active last cycle.

   // Two flops on every strobe; the address and data are held stable by
   // the host across the strobe, so they are sampled only once it has settled.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctl_meta <= 3'h7;
         ctl_sync <= 3'h7;
      end
      else
      begin
         ctl_meta <= {link.chip_select_low, link.read_strobe_low, link.write_strobe_low};
         ctl_sync <= ctl_meta;
      end
   end

   assign rd_active = !ctl_sync[2] && !ctl_sync[1];
   assign wr_active = !ctl_sync[2] && !ctl_sync[0];

   // Edge memory for cycle start and end detection.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rd_was <= 1'b0;
         wr_was <= 1'b0;
      end
      else
      begin
         rd_was <= rd_active;
         wr_was <= wr_active;
      end
   end

   logic rd_start;                       // One pulse per read cycle.
   logic wr_end;                         // One pulse per write cycle.
   assign rd_start = rd_active && !rd_was;
   assign wr_end   = wr_was && !wr_active;

   // -------------------------------------------------------------------
   // Address and select sampling
   // -------------------------------------------------------------------
   logic              fifo_mode;         // Select captured for this cycle.
   logic [1:0]        word_idx;          // A[2:1] captured for this cycle.
   logic [DATA_W-1:0] wr_data;           // Write data captured at end.

   // Select and address are taken together at the start of each cycle;
   // the host holds both steady like any address.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fifo_mode <= 1'b0;
         word_idx  <= 2'h0;
      end
      else if ((rd_active && !rd_was) || (wr_active && !wr_was))
      begin
         fifo_mode <= link.fifo_sel;
         word_idx  <= link.addr[SEL_LO +: 2];
      end
   end

   // The host bus is still driven while the synced strobe lags, so the
   // data sampled while the cycle is seen active is the end-of-cycle value.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wr_data <= RST_DATA;
      end
      else if (wr_active)
      begin
         wr_data <= link.data;
      end
   end

   // -------------------------------------------------------------------
   // Data FIFOs
   // -------------------------------------------------------------------
   logic              rxf_valid;         // Receive FIFO holds a word.
   logic [DATA_W-1:0] rxf_data;          // Receive FIFO head.
   logic              rxf_pop;           // Receive FIFO pop.
   logic              txf_push;          // Transmit FIFO push.
   logic              txf_ready;         // Transmit FIFO has room.

   hpf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_data   (rx_word),
      .in_valid  (rx_word_valid),
      .in_ready  (rx_word_ready),
      .out_data  (rxf_data),
      .out_valid (rxf_valid),
      .out_ready (rxf_pop)
   );

   hpf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_data   (wr_data),
      .in_valid  (txf_push),
      .in_ready  (txf_ready),
      .out_data  (tx_word),
      .out_valid (tx_word_valid),
      .out_ready (tx_word_ready)
   );

   // -------------------------------------------------------------------
   // Access decode
   // -------------------------------------------------------------------
   // A full transmit FIFO drops the word; the host must pace its writes.
   assign txf_push = wr_end && fifo_mode && txf_ready;
   // Read pop happens at the cycle after start, once select is captured.
   logic rd_go;                          // Read cycle decode pulse.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rd_go <= 1'b0;
      end
      else
      begin
         rd_go <= rd_start;
      end
   end
   assign rxf_pop = rd_go && (fifo_mode || word_idx == RX_DATA_IDX) && rxf_valid;

   // Register write port for addressed writes.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         reg_wdata   <= RST_DATA;
         reg_windex  <= 2'h0;
         reg_wstrobe <= 1'b0;
      end
      else
      begin
         reg_wstrobe <= wr_end && !fifo_mode;
         if (wr_end && !fifo_mode)
         begin
            reg_wdata  <= wr_data;
            reg_windex <= word_idx;
         end
      end
   end

   // -------------------------------------------------------------------
   // Burst counting
   // -------------------------------------------------------------------
   logic [4:0] burst_cnt;                // Addressed reads since a gap.

   // A gap is chip select high; FIFO-direct reads never count.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         burst_cnt     <= 5'h00;
         burst_overrun <= 1'b0;
      end
      else if (ctl_sync[2])
      begin
         burst_cnt <= 5'h00;
      end
      else if (rd_go && !fifo_mode)
      begin
         burst_cnt <= burst_cnt + 5'h01;
         if (burst_cnt >= 5'(BURST_MAX))
         begin
            burst_overrun <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] count_snap;        // Counter frozen at read start.
   logic [DATA_W-1:0] rd_word;           // Word driven on the bus.

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         count_snap <= RST_DATA;
      end
      else if (rd_start)
      begin
         count_snap <= event_count;
      end
   end

   // Output word chosen one cycle after start; an empty FIFO reads zero.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rd_word <= RST_DATA;
      end
      else if (rd_go)
      begin
         if (fifo_mode)
         begin
            rd_word <= rxf_valid ? rxf_data : RST_DATA;
         end
         else
         begin
            unique case (word_idx)
               RX_DATA_IDX: rd_word <= rxf_valid ? rxf_data : RST_DATA;
               STATUS_IDX:  rd_word <= {14'h0000, tx_word_valid, rxf_valid};
               COUNT_IDX:   rd_word <= count_snap;
               TEST_IDX:    rd_word <= TEST_WORD;
            endcase
         end
      end
   end

   // The bus is driven only while the raw strobes ask for a read.
   assign link.dev_data_out = rd_word;
   assign link.dev_data_oe  = !link.chip_select_low && !link.read_strobe_low;
endmodule : hpf_device

/* File: hpf_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module hpf_fifo #(
   parameter int WIDTH = 16,             // Word width.
   parameter int DEPTH = 8               // Word count, power of two.
) (
   input  wire logic             sys_clk,   // System clock.
   input  wire logic             sys_rst,   // Synchronous reset.
   input  wire logic [WIDTH-1:0] in_data,   // Word to store.
   input  wire logic             in_valid,  // Word offered.
   output logic                  in_ready,  // Room available.
   output logic      [WIDTH-1:0] out_data,  // Oldest word.
   output logic                  out_valid, // Word available.
   input  wire logic             out_ready  // Word taken.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];        // Storage array.
   logic [AW:0]      wr_ptr;             // Write pointer with wrap bit.
   logic [AW:0]      rd_ptr;             // Read pointer with wrap bit.
   logic             push;               // Store this cycle.
   logic             pop;                // Release this cycle.

   // Full when pointers differ only in the wrap bit; empty when equal.
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write; the array needs no reset since pointers guard it.
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointer update.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : hpf_fifo

/* File: hpf_host.sv */
// Host end: turns single read/write requests into paced strobe cycles.
// Assumes the device end samples strobes with a two-flop synchroniser.
`timescale 1ns/1ps
module hpf_host
   import hpf_pkg::*;
(
   input  wire logic              sys_clk,     // System clock.
   input  wire logic              sys_rst,     // Synchronous reset.
   hpf_link_if.host               link,        // Pins towards the device.
   input  wire logic              req_valid,   // Request offered.
   output logic                   req_ready,   // Request taken when valid.
   input  wire logic              req_write,   // High for write.
   input  wire logic              req_fifo,    // FIFO-direct select.
   input  wire logic [ADDR_W-1:0] req_addr,    // Address A[7:1].
   input  wire logic [DATA_W-1:0] req_wdata,   // Write data.
   output logic      [DATA_W-1:0] rsp_data,    // Read data.
   output logic                   rsp_valid    // Read data pulse.
);
   typedef enum logic [1:0] {IDLE, LOW, HIGH} hpf_hstate_t;
   localparam int LOW_CLKS  = (LOW_MIN_CLKS > SYNC_CLKS + 2) ? LOW_MIN_CLKS : SYNC_CLKS + 2;
   localparam int HIGH_CLKS = (HIGH_MIN_CLKS > SYNC_CLKS) ? HIGH_MIN_CLKS : SYNC_CLKS;
   hpf_hstate_t state;                   // Cycle phase.
   logic [3:0]  cnt;                     // Phase timer.
   logic        is_wr;                   // Current cycle is a write.

   assign req_ready = (state == IDLE);

   // Each request is one strobe cycle; the low phase exceeds and the high phase
   // matches the synchroniser delay, so low plus high also covers the 165 ns cycle.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state                 <= IDLE;
         cnt                   <= 4'h0;
         is_wr                 <= 1'b0;
         link.chip_select_low  <= 1'b1;
         link.read_strobe_low  <= 1'b1;
         link.write_strobe_low <= 1'b1;
         link.fifo_sel         <= 1'b0;
         link.addr             <= '0;
         link.host_data_out    <= RST_DATA;
         link.host_data_oe     <= 1'b0;
         rsp_data              <= RST_DATA;
         rsp_valid             <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         unique case (state)
            IDLE:
            begin
               if (req_valid)
               begin
                  state                 <= LOW;
                  cnt                   <= 4'(LOW_CLKS - 1);
                  is_wr                 <= req_write;
                  link.chip_select_low  <= 1'b0;
                  link.read_strobe_low  <= req_write;
                  link.write_strobe_low <= !req_write;
                  link.fifo_sel         <= req_fifo;
                  link.addr             <= req_addr;
                  link.host_data_out    <= req_wdata;
                  link.host_data_oe     <= req_write;
               end
            end
            LOW:
            begin
               if (cnt == 4'h0)
               begin
                  state                 <= HIGH;
                  cnt                   <= 4'(HIGH_CLKS - 1);
                  link.chip_select_low  <= 1'b1;
                  link.read_strobe_low  <= 1'b1;
                  link.write_strobe_low <= 1'b1;
                  if (!is_wr)
                  begin
                     rsp_data  <= link.data;
                     rsp_valid <= 1'b1;
                  end
               end
               else
               begin
                  cnt <= cnt - 4'h1;
               end
            end
            HIGH:
            begin
               // Data stays driven through the whole gap, because the device's
               // synchroniser sees the rising strobe two cycles late.
               if (cnt == 4'h0)
               begin
                  state             <= IDLE;
                  link.host_data_oe <= 1'b0;
               end
               else
               begin
                  cnt <= cnt - 4'h1;
               end
            end
         endcase
      end
   end
endmodule : hpf_host

/* File: hpf_link_asserts.sv */
// Concurrent checks on the pins of the host parallel link.
// Assumes the bench instantiates it beside the link interface, one clock domain.
`timescale 1ns/1ps
module hpf_link_asserts
   import hpf_pkg::*;
(
   input wire logic              sys_clk,          // System clock.
   input wire logic              sys_rst,          // Synchronous reset.
   input wire logic              chip_select_low,  // Active-low chip select.
   input wire logic              read_strobe_low,  // Active-low read strobe.
   input wire logic              write_strobe_low, // Active-low write strobe.
   input wire logic              fifo_sel,         // FIFO-direct select.
   input wire logic [ADDR_W-1:0] addr,             // Address A[7:1].
   input wire logic [DATA_W-1:0] host_data_out,    // Host data drive.
   input wire logic              host_data_oe,     // Host drives the bus.
   input wire logic [DATA_W-1:0] dev_data_out,     // Device data drive.
   input wire logic              dev_data_oe       // Device drives the bus.
);
   // -------------------------------------------------------------------
   // Cycle activity decoded straight from the pins
   // -------------------------------------------------------------------
   wire rd_act = !chip_select_low && !read_strobe_low;   // Read cycle open.
   wire wr_act = !chip_select_low && !write_strobe_low;  // Write cycle open.
   wire act    = rd_act || wr_act;                       // Any cycle open.

   // One clock and one reset, so both are given once for every check.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   chk_read_drive: assert property (dev_data_oe == rd_act)
      else $error("Device bus drive does not follow the read strobes.");
   chk_bus_no_fight: assert property (!(dev_data_oe && host_data_oe))
      else $error("Host and device drive the bus together.");
   chk_rdwr_exclusive: assert property (!(rd_act && wr_act))
      else $error("Read and write cycles overlap.");
   chk_read_low_len: assert property ($rose(rd_act) |-> rd_act[*5])
      else $error("Read strobes released early.");
   chk_write_low_len: assert property ($rose(wr_act) |-> wr_act[*5])
      else $error("Write strobes released early.");
   chk_high_min: assert property ($fell(act) |-> (!act)[*3])
      else $error("Strobes not held high long enough.");
   chk_cycle_min: assert property ($rose(act) |=> (!$rose(act))[*8])
      else $error("Cycles started too close together.");
   chk_addr_stable: assert property (act && $past(act) |-> $stable(addr) && $stable(fifo_sel))
      else $error("Address or FIFO select moved within a cycle.");
   chk_wdata_stable: assert property (wr_act && $past(wr_act) |-> $stable(host_data_out))
      else $error("Write data moved within a write cycle.");
   chk_write_drive: assert property (wr_act |-> host_data_oe)
      else $error("Host not driving data during a write.");
endmodule // hpf_link_asserts

/* File: hpf_link_if.sv */
// Pin-level link between host and device ends.
// Assumes both ends run on the same sys_clk; the data bus is resolved here.
`timescale 1ns/1ps
interface hpf_link_if;
   import hpf_pkg::*;
   logic              chip_select_low;   // Active-low chip select.
   logic              read_strobe_low;   // Active-low read strobe.
   logic              write_strobe_low;  // Active-low write strobe.
   logic              fifo_sel;          // FIFO-direct select, timed like address.
   logic [ADDR_W-1:0] addr;              // Address A[7:1].
   logic [DATA_W-1:0] host_data_out;     // Host data drive.
   logic              host_data_oe;      // Host drives the bus.
   logic [DATA_W-1:0] dev_data_out;      // Device data drive.
   logic              dev_data_oe;       // Device drives the bus.
   logic [DATA_W-1:0] data;              // Resolved bus level.

   // Resolve the shared bus; an undriven bus reads as zero.
   assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);

   modport host (
      output chip_select_low, read_strobe_low, write_strobe_low, fifo_sel, addr,
      output host_data_out, host_data_oe,
      input  data
   );
   modport device (
      input  chip_select_low, read_strobe_low, write_strobe_low, fifo_sel, addr,
      output dev_data_out, dev_data_oe,
      input  data
   );
endinterface : hpf_link_if

/* File: hpf_pkg.sv */
// Shared constants and types for the host parallel FIFO-direct port.
// Assumes a single 20 MHz system clock on both ends of the link.
package hpf_pkg;
   // -------------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------------
   localparam int DATA_W      = 16;         // Data bus width.
   localparam int ADDR_W      = 7;          // Address bits A[7:1].
   localparam int FIFO_DEPTH  = 8;          // Words in each data FIFO.
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;     // System clock period.
   localparam int CYCLE_MIN_NS    = 165;    // Least whole cycle time.
   localparam int LOW_MIN_NS      = 32;     // Least strobe low time.
   localparam int HIGH_MIN_NS     = 13;     // Least strobe high time.
   localparam int CYCLE_MIN_CLKS  = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_MIN_CLKS    = (LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_MIN_CLKS   = (HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Extra low time so the device's two-flop synchroniser sees the strobe.
   localparam int SYNC_CLKS       = 3;
   // -------------------------------------------------------------------
   // Burst and address decode
   // -------------------------------------------------------------------
   localparam int BURST_MAX       = 16;     // Addressed burst word limit.
   localparam int SEL_LO          = 0;      // A[2:1] sit at index 1:0.
   localparam logic [1:0] RX_DATA_IDX  = 2'h0; // Word index of rx data.
   localparam logic [1:0] STATUS_IDX   = 2'h1; // Word index of status.
   localparam logic [1:0] COUNT_IDX    = 2'h2; // Word index of counter.
   localparam logic [1:0] TEST_IDX     = 2'h3; // Word index of test word.
   localparam logic [15:0] TEST_WORD   = 16'h4321; // Fixed pattern word.
   localparam logic [15:0] RST_DATA    = 16'h0000; // Data after reset.
endpackage : hpf_pkg
